// >>> bench/smr_host_model.sv
// Host controller model: byte register accesses and transaction close.
// Assumes the bench calls its tasks; all lines change at the falling edge.
`timescale 1ns/1ps
`default_nettype none

module smr_host_model (
    // Clock
    input  wire logic       clock_i,
    // Register access toward the block
    output logic      [7:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic            xfer_end_o,
    input  wire logic [7:0] reg_rdata_i
);
    // Idle bus at time zero
    initial {reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o, xfer_end_o} = 19'h00000;

    // One byte access; released address and data show inverses, strobes go low
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                          input logic fin, output logic [7:0] q);
        @(negedge clock_i);
        reg_addr_o  = a;
        reg_wdata_o = d;
        reg_wr_o    = wr;
        reg_rd_o    = ~wr;
        xfer_end_o  = fin;
        @(negedge clock_i);
        q           = reg_rdata_i;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        xfer_end_o  = 1'b0;
        reg_addr_o  = ~a;
        reg_wdata_o = ~d;
    endtask : access

    // Stop condition or chip-select release with no data
    task automatic close;
        @(negedge clock_i);
        xfer_end_o = 1'b1;
        @(negedge clock_i);
        xfer_end_o = 1'b0;
    endtask : close
endmodule : smr_host_model

`default_nettype wire

// >>> bench/smr_top_properties.sv
// Checker for the mode/status and soft-reset bank, on its top ports only.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module smr_top_properties #(
    parameter int RESET_DELAY_CYCLES = 15000,
    parameter int MOTION_DEFAULT     = 1
) (
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       reset_i,
    // Register access
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic       xfer_end_i,
    input  wire logic [7:0] reg_rdata_o,
    // Pins and status
    input  wire logic       boot_select_pin_i,
    input  wire logic       second_irq_pin_i,
    input  wire logic [1:0] operating_state_code_o,
    input  wire logic       debounce_clear_o,
    input  wire logic       block_reset_o,
    input  wire logic       serial_reset_o
);
    logic rst_wr;  // Soft-reset request seen on the bus
    int   since_r; // Cycles since the last request, saturating
    logic ended_r; // Transaction closed since the last request

    assign rst_wr = reg_wr_i && (reg_addr_i == smr_pkg::ADDR_SENSOR_CFG1) && reg_wdata_i[7];

    // Request age, saturated from reset
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            since_r <= RESET_DELAY_CYCLES + 8;
        end else if (rst_wr) begin
            since_r <= 0;
        end else if (since_r < RESET_DELAY_CYCLES + 8) begin
            since_r <= since_r + 1;
        end
    end

    // A close with the request counts
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            ended_r <= 1'b0;
        end else if (xfer_end_i) begin
            ended_r <= 1'b1;
        end else if (rst_wr) begin
            ended_r <= 1'b0;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    // Trigger edge while waiting
    sequence s_trig_seen;
        (operating_state_code_o == smr_pkg::CODE_TRIG_WAIT) ##0 $rose(second_irq_pin_i);
    endsequence

    a_status_read: assert property (
        reg_rd_i && reg_addr_i == smr_pkg::ADDR_MODE_STATUS && $stable(operating_state_code_o)
        |=> reg_rdata_o == {6'h00, $past(operating_state_code_o)}) else $error("bad status read");
    a_rst_bit_zero: assert property (
        reg_rd_i && reg_addr_i == smr_pkg::ADDR_SENSOR_CFG1 |=> !reg_rdata_o[7]) else $error("reset bit read 1");
    a_reset_pair: assert property (
        block_reset_o |-> serial_reset_o ##1 !block_reset_o) else $error("reset unpaired");
    a_reset_delay: assert property (
        block_reset_o |-> since_r >= RESET_DELAY_CYCLES) else $error("reset early");
    a_reset_waits_end: assert property (
        block_reset_o |-> ended_r) else $error("reset mid transfer");
    a_no_trig_strap: assert property (
        boot_select_pin_i |-> operating_state_code_o != smr_pkg::CODE_TRIG_WAIT) else $error("trigger with strap");
    a_trig_to_wake: assert property (
        s_trig_seen |-> ##[1:4] operating_state_code_o == smr_pkg::CODE_WAKE) else $error("no wake");
    a_clear_on_entry: assert property (
        $changed(operating_state_code_o) && operating_state_code_o != smr_pkg::CODE_STANDBY
        |-> ##[0:1] debounce_clear_o) else $error("no debounce clear");
    a_reset_standby: assert property (
        block_reset_o |-> operating_state_code_o == smr_pkg::CODE_STANDBY) else $error("mode kept");
endmodule : smr_top_properties

`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench for the mode/status and soft-reset bank.
// Inputs change at the falling edge.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam int DELAY = 20; // Short soft-reset delay keeps the run brief
    logic       clock_i = 1'b0;
    logic       reset_i = 1'b1;
    logic       boot_pin, irq2_in, meas_done, sleep_req, wake_req;
    logic [7:0] addr, wdata, rdata;
    logic       wr, rd, xend;
    logic       irq1, irq1_oe_n, irq2, irq2_oe_n, dbc, blk, ser;
    logic [1:0] code;
    int         failures = 0, n_compared = 0, n_blk = 0, n, n0;

    always #10 clock_i = ~clock_i;

    // Count soft-reset pulses
    always @(posedge clock_i) if (blk === 1'b1) n_blk++;

    smr_host_model smr_host_model_inst (.clock_i(clock_i), .reg_addr_o(addr), .reg_wdata_o(wdata),
        .reg_wr_o(wr), .reg_rd_o(rd), .xfer_end_o(xend), .reg_rdata_i(rdata));
    smr_top #(.RESET_DELAY_CYCLES(DELAY)) smr_top_inst (.clock_i, .reset_i,
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .xfer_end_i(xend),
        .reg_rdata_o(rdata), .boot_select_pin_i(boot_pin), .second_irq_pin_i(irq2_in),
        .first_irq_pin_o(irq1), .first_irq_pin_oe_n_o(irq1_oe_n), .second_irq_pin_o(irq2),
        .second_irq_pin_oe_n_o(irq2_oe_n), .measurement_done_i(meas_done), .sleep_request_i(sleep_req),
        .wake_request_i(wake_req), .operating_state_code_o(code), .debounce_clear_o(dbc),
        .block_reset_o(blk), .serial_reset_o(ser));

    task automatic cyc(input int k);
        repeat (k) @(negedge clock_i);
    endtask : cyc

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic fin);
        logic [7:0] q;
        smr_host_model_inst.access(1'b1, a, d, fin, q);
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        smr_host_model_inst.access(1'b0, a, 8'h00, 1'b0, q);
        chk(q, exp);
    endtask : rd_chk

    // Bounded wait for the next soft-reset pulse
    task automatic wait_blk(input int lim, output int k);
        int b0;
        b0 = n_blk;
        k = 0;
        while (n_blk == b0 && k < lim) begin
            cyc(1);
            k++;
        end
    endtask : wait_blk

    // Strap is set while reset is held
    task automatic do_reset(input logic strap);
        reset_i = 1'b1;
        boot_pin = strap;
        cyc(2);
        reset_i = 1'b0;
        cyc(5);
    endtask : do_reset

    task automatic wrap_up;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up

    // Watchdog; tests need under 10 us
    initial begin
        #50us;
        failures++;
        $display("watchdog expired");
        wrap_up();
    end

    initial begin
        boot_pin = 1'b0; irq2_in = 1'b0; meas_done = 1'b0; sleep_req = 1'b0; wake_req = 1'b0;
        do_reset(1'b0);
        rd_chk(8'h14, 8'h00);
        rd_chk(8'h15, 8'h00);
        rd_chk(8'h18, 8'h00);
        rd_chk(8'h20, 8'h04);
        rd_chk(8'h33, 8'h00);
        wr_reg(8'h15, 8'h7E, 1'b0);
        rd_chk(8'h15, 8'h7E);
        wr_reg(8'h14, 8'hFF, 1'b0);
        rd_chk(8'h14, 8'h00);
        $display("test registers done");
        // Trigger mode: wait, measure, wait again
        wr_reg(8'h18, 8'h05, 1'b0);
        wr_reg(8'h15, 8'h01, 1'b0);
        cyc(2);
        rd_chk(8'h14, 8'h03);
        irq2_in = 1'b1;
        cyc(6);
        chk({6'h00, code}, 8'h01);
        meas_done = 1'b1;
        cyc(1);
        meas_done = 1'b0;
        cyc(3);
        chk({6'h00, code}, 8'h03);
        irq2_in = 1'b0;
        $display("test trigger done");
        // Soft reset held off until the transaction closes
        wr_reg(8'h15, 8'h81, 1'b0);
        rd_chk(8'h15, 8'h01);
        n0 = n_blk;
        cyc(40);
        chk(8'(n_blk - n0), 8'h00);
        smr_host_model_inst.close();
        wait_blk(10, n);
        chk(8'(n_blk - n0), 8'h01);
        cyc(10);
        rd_chk(8'h18, 8'h01);
        rd_chk(8'h15, 8'h00);
        rd_chk(8'h14, 8'h00);
        wr_reg(8'h15, 8'h80, 1'b1);
        wait_blk(DELAY + 10, n);
        chk(8'(n >= DELAY && n < DELAY + 10), 8'h01);
        $display("test soft reset done");
        // Wake level on the pins, then sleep and back
        wr_reg(8'h18, 8'h03, 1'b0);
        wr_reg(8'h20, 8'h05, 1'b0);
        wr_reg(8'h15, 8'h01, 1'b0);
        cyc(3);
        chk({6'h00, code}, 8'h01);
        chk({6'h00, irq1_oe_n, irq1}, 8'h03);
        wr_reg(8'h20, 8'h07, 1'b0);
        cyc(3);
        chk({5'h00, irq2_oe_n, irq1, irq2}, 8'h05);
        sleep_req = 1'b1;
        cyc(1);
        sleep_req = 1'b0;
        cyc(3);
        chk({6'h00, code}, 8'h02);
        wake_req = 1'b1;
        cyc(1);
        wake_req = 1'b0;
        cyc(3);
        chk({6'h00, code}, 8'h01);
        n0 = n_blk;
        wr_reg(8'h15, 8'h81, 1'b1);
        wait_blk(DELAY + 10, n);
        chk(8'(n_blk - n0), 8'h01);
        $display("test wake output done");
        // Strap high: wake by default, never trigger-wait
        do_reset(1'b1);
        chk({6'h00, code}, 8'h01);
        rd_chk(8'h15, 8'h03);
        wr_reg(8'h18, 8'h04, 1'b0);
        wr_reg(8'h15, 8'h00, 1'b0);
        wr_reg(8'h15, 8'h01, 1'b0);
        cyc(3);
        chk({6'h00, code}, 8'h01);
        $display("test strap high done");
        wrap_up();
    end
endmodule : tb_top

bind smr_top smr_top_properties #(.RESET_DELAY_CYCLES(RESET_DELAY_CYCLES), .MOTION_DEFAULT(MOTION_DEFAULT))
    smr_top_properties_inst (.clock_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .xfer_end_i,
    .reg_rdata_o, .boot_select_pin_i, .second_irq_pin_i, .operating_state_code_o, .debounce_clear_o,
    .block_reset_o, .serial_reset_o);

`default_nettype wire

// >>> logic/smr_delay.sv
// One-shot down counter: start loads the count, done pulses at zero.
// Start is a one-cycle pulse; a new start restarts.
`timescale 1ns/1ps
`default_nettype none

module smr_delay #(
    parameter int CYCLES = 15000,
    parameter int WIDTH  = 16
) (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic reset_i,
    // Control
    input  wire logic start_i,
    output logic      busy_o,
    output logic      done_o
);

    localparam logic [WIDTH-1:0] LOAD = WIDTH'(CYCLES - 1);

    logic [WIDTH-1:0] count_r;  // Remaining cycles

    // Count down while busy; done is registered
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            count_r <= '0;
            busy_o  <= 1'b0;
            done_o  <= 1'b0;
        end else if (start_i) begin
            count_r <= LOAD;
            busy_o  <= 1'b1;
            done_o  <= 1'b0;
        end else if (busy_o && count_r == '0) begin
            busy_o  <= 1'b0;
            done_o  <= 1'b1;
        end else begin
            count_r <= busy_o ? count_r - 1'b1 : count_r;
            done_o  <= 1'b0;
        end
    end

endmodule : smr_delay

`default_nettype wire

// >>> logic/smr_pkg.sv
// Constants and types shared by the mode/status and soft-reset register bank.
// Assumes a serial front end that hands over byte-wide register accesses.
`default_nettype none

package smr_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_MODE_STATUS   = 8'h14;
    localparam logic [7:0] ADDR_SENSOR_CFG1   = 8'h15;
    localparam logic [7:0] ADDR_SENSOR_CFG4   = 8'h18;
    localparam logic [7:0] ADDR_WAKE_CTRL     = 8'h20;

    // Field positions in sensor_config_one
    localparam int CFG1_ACTIVE_BIT = 0;
    localparam int CFG1_RST_BIT    = 7;

    // Field positions in sensor_config_four
    localparam int CFG4_POL_BIT    = 0;
    localparam int CFG4_DRIVE_BIT  = 1;
    localparam int CFG4_FSEL_BIT   = 2;
    localparam int CFG4_BOOTD_BIT  = 3;

    // Field positions in the wake control register
    localparam int WAKE_EN_BIT     = 0;
    localparam int WAKE_PIN_BIT    = 1;
    localparam int WAKE_MOTION_BIT = 2;

    // Values after reset
    localparam logic [7:0] CFG1_RESET_LOW  = 8'h00;
    localparam logic [7:0] CFG1_RESET_HIGH = 8'h03;
    localparam logic [7:0] CFG4_RESET      = 8'h00;
    localparam logic [7:0] WAKE_RESET      = 8'h04;

    // Writable masks and the soft-reset keep mask; reset bit never stored
    localparam logic [7:0] CFG1_STORE_MASK = 8'h7F;
    localparam logic [7:0] CFG4_STORE_MASK = 8'h0F;
    localparam logic [7:0] WAKE_STORE_MASK = 8'h07;
    localparam logic [7:0] CFG4_KEEP_MASK  = 8'h0B;

    // Operating mode codes
    localparam logic [1:0] CODE_STANDBY   = 2'h0;
    localparam logic [1:0] CODE_WAKE      = 2'h1;
    localparam logic [1:0] CODE_SLEEP     = 2'h2;
    localparam logic [1:0] CODE_TRIG_WAIT = 2'h3;

    // Soft-reset start delay
    localparam int CLOCK_MHZ          = 50;
    localparam int RESET_DELAY_US     = 300;
    localparam int RESET_DELAY_CYCLES = RESET_DELAY_US * CLOCK_MHZ;

    // Strap settle count
    localparam logic [1:0] BOOT_SETTLE = 2'h3;

    // Operating states
    typedef enum logic [1:0] {
        ST_STANDBY,
        ST_WAKE,
        ST_SLEEP,
        ST_TRIG_WAIT
    } smr_mode_type;

endpackage : smr_pkg

`default_nettype wire

// >>> logic/smr_sync.sv
// Two-flop synchroniser for pin inputs.
// Assumes inputs are asynchronous to clock_i; width is a parameter.
`timescale 1ns/1ps
`default_nettype none

module smr_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             reset_i,
    // Pin side
    input  wire logic [WIDTH-1:0] async_i,
    // Clock side
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_r;  // First stage, read only by the second

    // Two stages, first read only here
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            meta_r <= '0;
            sync_o <= '0;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end

endmodule : smr_sync

`default_nettype wire

// >>> logic/smr_top.sv
// Mode status and soft-reset register bank of the sensor.
// Assumes a serial front end on clock_i giving byte accesses
// and a one-cycle pulse at transaction end (stop or CS release).
//
// Function
// - Two-bit mode code, defaults by boot strap
// - No trigger-wait mode when boot pin high
// - Function select bit enables external trigger mode
// - Trigger wait 11b, measuring 01b, back to 11b
// - Wake level driven on selected interrupt pin; second pin stays released while function select makes it the trigger input
// - Debounce counters cleared on entry to wake, sleep or trigger wait
// - Soft reset accepted in every mode
// - Soft reset reloads defaults, keeps pin bits
// - Soft reset also resets serial interface
// - Reset waits for end of transaction
// - Soft-reset bit always reads zero
// - Reset starts 300 to 500 us later
// - Mode code in low bits at 14h
`timescale 1ns/1ps
`default_nettype none

module smr_top #(
    parameter int RESET_DELAY_CYCLES = smr_pkg::RESET_DELAY_CYCLES,
    parameter int MOTION_DEFAULT     = 1
) (
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       reset_i,
    // Register access from the serial front end
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic       xfer_end_i,
    output logic      [7:0] reg_rdata_o,
    // Strap and pins
    input  wire logic       boot_select_pin_i,
    input  wire logic       second_irq_pin_i,
    output logic            first_irq_pin_o,
    output logic            first_irq_pin_oe_n_o,
    output logic            second_irq_pin_o,
    output logic            second_irq_pin_oe_n_o,
    // Sensing core handshakes
    input  wire logic       measurement_done_i,
    input  wire logic       sleep_request_i,
    input  wire logic       wake_request_i,
    // Outputs to other blocks
    output logic      [1:0] operating_state_code_o,
    output logic            debounce_clear_o,
    output logic            block_reset_o,
    output logic            serial_reset_o
);

    // Mode state to its printed code
    function automatic logic [1:0] mode_code(input smr_pkg::smr_mode_type m);
        case (m)
            smr_pkg::ST_STANDBY:   mode_code = smr_pkg::CODE_STANDBY;
            smr_pkg::ST_WAKE:      mode_code = smr_pkg::CODE_WAKE;
            smr_pkg::ST_SLEEP:     mode_code = smr_pkg::CODE_SLEEP;
            smr_pkg::ST_TRIG_WAIT: mode_code = smr_pkg::CODE_TRIG_WAIT;
            default:               mode_code = smr_pkg::CODE_STANDBY;
        endcase
    endfunction : mode_code

    // Synchronised pins
    logic [1:0]            pins_sync;      // {second irq pin, boot strap}
    logic                  boot_high;      // Boot strap level
    logic                  trig_in;        // Trigger level on second pin
    logic                  trig_prev_r;    // Trigger level one cycle ago
    logic                  trig_edge;      // Rising edge of trigger

    // Register contents
    logic [7:0]            cfg1_r;         // sensor_config_one, bit 7 unused
    logic [7:0]            cfg4_r;         // sensor_config_four
    logic [7:0]            wake_r;         // Wake output control

    // Soft reset sequencing
    logic                  rst_pending_r;  // Request written, not started
    logic                  rst_xfer_end_r; // Transaction has closed since
    logic                  rst_go;         // Start the reset sequence
    logic                  reload;         // Hard or soft defaults load
    logic                  delay_start;    // Launch the start delay
    logic                  delay_busy;     // Delay still running
    logic [1:0]            boot_wait_r;    // Strap settle countdown
    logic                  boot_apply;     // Apply strap-dependent defaults

    // Mode state
    smr_pkg::smr_mode_type mode_r;
    smr_pkg::smr_mode_type mode_nxt;
    logic                  trig_en;
    logic                  active;
    logic                  wr_cfg1;
    logic                  wr_cfg4;
    logic                  wr_wake;
    logic                  wake_drive;
    logic                  second_is_input;
    logic                  irq1_level;     // First pin level before its flop
    logic                  irq2_level;     // Second pin level before its flop

    // Strap and trigger pass two flops before use
    smr_sync #(
        .WIDTH (2)
    ) u_sync (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .async_i ({second_irq_pin_i, boot_select_pin_i}),
        .sync_o  (pins_sync)
    );

    assign boot_high = pins_sync[0];
    assign trig_in   = pins_sync[1];
    assign trig_edge = trig_in & ~trig_prev_r;

    // Remember trigger level for edge detection
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            trig_prev_r <= 1'b0;
        end else begin
            trig_prev_r <= trig_in;
        end
    end

    // Write strobes per register
    assign wr_cfg1 = reg_wr_i && reg_addr_i == smr_pkg::ADDR_SENSOR_CFG1;
    assign wr_cfg4 = reg_wr_i && reg_addr_i == smr_pkg::ADDR_SENSOR_CFG4;
    assign wr_wake = reg_wr_i && reg_addr_i == smr_pkg::ADDR_WAKE_CTRL;

    // Trigger mode only when selected and strap is low
    assign trig_en = cfg4_r[smr_pkg::CFG4_FSEL_BIT] & ~boot_high;
    assign active  = cfg1_r[smr_pkg::CFG1_ACTIVE_BIT];

    // Soft reset request: taken in any mode, deferred to transaction end
    assign delay_start = wr_cfg1 && reg_wdata_i[smr_pkg::CFG1_RST_BIT];
    assign rst_go      = rst_pending_r && rst_xfer_end_r && !delay_busy
                         && !delay_start;
    assign reload      = reset_i | rst_go;

    // Start delay at its minimum
    smr_delay #(
        .CYCLES (RESET_DELAY_CYCLES),
        .WIDTH  (16)
    ) u_delay (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .start_i (delay_start),
        .busy_o  (delay_busy),
        .done_o  ()
    );

    // Pending flag and transaction-closed flag
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rst_pending_r  <= 1'b0;
            rst_xfer_end_r <= 1'b0;
        end else if (delay_start) begin
            // A new request restarts delay and close wait
            rst_pending_r  <= 1'b1;
            rst_xfer_end_r <= xfer_end_i;
        end else if (rst_go) begin
            rst_pending_r  <= 1'b0;
            rst_xfer_end_r <= 1'b0;
        end else if (xfer_end_i && rst_pending_r) begin
            rst_xfer_end_r <= 1'b1;
        end
    end

    // Reset pulses to functional blocks and the serial front end
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            block_reset_o  <= 1'b0;
            serial_reset_o <= 1'b0;
        end else begin
            block_reset_o  <= rst_go;
            serial_reset_o <= rst_go;
        end
    end

    // Strap settle countdown after any defaults load
    always_ff @(posedge clock_i) begin
        if (reload) begin
            boot_wait_r <= smr_pkg::BOOT_SETTLE;
        end else if (boot_wait_r != 2'h0) begin
            boot_wait_r <= boot_wait_r - 2'h1;
        end
    end

    assign boot_apply = boot_wait_r == 2'h1;

    // sensor_config_one: reset bit is never stored
    always_ff @(posedge clock_i) begin
        if (reload) begin
            cfg1_r <= smr_pkg::CFG1_RESET_LOW;
        end else if (boot_apply) begin
            // Strap known now; active by default when strapped high
            cfg1_r <= boot_high ? smr_pkg::CFG1_RESET_HIGH
                                : smr_pkg::CFG1_RESET_LOW;
        end else if (wr_cfg1) begin
            cfg1_r <= reg_wdata_i & smr_pkg::CFG1_STORE_MASK;
        end
    end

    // sensor_config_four: pin bits survive a soft reset
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            cfg4_r <= smr_pkg::CFG4_RESET;
        end else if (rst_go) begin
            cfg4_r <= cfg4_r & smr_pkg::CFG4_KEEP_MASK;
        end else if (wr_cfg4) begin
            cfg4_r <= reg_wdata_i & smr_pkg::CFG4_STORE_MASK;
        end
    end

    // Wake output control, including the motion detect setting
    always_ff @(posedge clock_i) begin
        if (reload) begin
            wake_r <= MOTION_DEFAULT != 0 ? smr_pkg::WAKE_RESET : 8'h00;
        end else if (wr_wake) begin
            wake_r <= reg_wdata_i & smr_pkg::WAKE_STORE_MASK;
        end
    end

    // Next operating mode
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            smr_pkg::ST_STANDBY: begin
                if (boot_apply && boot_high && wake_r[smr_pkg::WAKE_MOTION_BIT]) begin
                    mode_nxt = smr_pkg::ST_WAKE;
                end else if (active && !boot_apply) begin
                    mode_nxt = trig_en ? smr_pkg::ST_TRIG_WAIT : smr_pkg::ST_WAKE;
                end
            end
            smr_pkg::ST_WAKE: begin
                if (!active && !boot_apply) begin
                    mode_nxt = smr_pkg::ST_STANDBY;
                end else if (trig_en && measurement_done_i) begin
                    mode_nxt = smr_pkg::ST_TRIG_WAIT;
                end else if (!trig_en && sleep_request_i) begin
                    mode_nxt = smr_pkg::ST_SLEEP;
                end
            end
            smr_pkg::ST_SLEEP: begin
                if (!active) begin
                    mode_nxt = smr_pkg::ST_STANDBY;
                end else if (trig_en) begin
                    mode_nxt = smr_pkg::ST_TRIG_WAIT;
                end else if (wake_request_i) begin
                    mode_nxt = smr_pkg::ST_WAKE;
                end
            end
            smr_pkg::ST_TRIG_WAIT: begin
                if (!active) begin
                    mode_nxt = smr_pkg::ST_STANDBY;
                end else if (!trig_en) begin
                    mode_nxt = smr_pkg::ST_WAKE;
                end else if (trig_edge) begin
                    mode_nxt = smr_pkg::ST_WAKE;
                end
            end
            default: begin
                mode_nxt = smr_pkg::ST_STANDBY;
            end
        endcase
    end

    // Mode register; a defaults load returns to standby first
    always_ff @(posedge clock_i) begin
        if (reload) begin
            mode_r <= smr_pkg::ST_STANDBY;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // Published mode code, registered
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            operating_state_code_o <= smr_pkg::CODE_STANDBY;
        end else if (rst_go) begin
            operating_state_code_o <= smr_pkg::CODE_STANDBY;
        end else begin
            operating_state_code_o <= mode_code(mode_nxt);
        end
    end

    // Debounce clear pulse on entry into wake, sleep or trigger wait
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            debounce_clear_o <= 1'b0;
        end else begin
            debounce_clear_o <= !reload && mode_nxt != mode_r
                                && mode_nxt != smr_pkg::ST_STANDBY;
        end
    end

    // Register read data; unmapped addresses read zero
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                smr_pkg::ADDR_MODE_STATUS: reg_rdata_o <= {6'h00, mode_code(mode_r)};
                smr_pkg::ADDR_SENSOR_CFG1: reg_rdata_o <= {1'b0, cfg1_r[6:0]};
                smr_pkg::ADDR_SENSOR_CFG4: reg_rdata_o <= cfg4_r;
                smr_pkg::ADDR_WAKE_CTRL:   reg_rdata_o <= wake_r;
                default:                   reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // Wake level is asserted while in wake with the output enabled
    assign wake_drive      = wake_r[smr_pkg::WAKE_EN_BIT] && mode_r == smr_pkg::ST_WAKE;
    assign second_is_input = cfg4_r[smr_pkg::CFG4_FSEL_BIT];
    // Asserted level equals the polarity bit, idle level its inverse
    assign irq1_level = (wake_drive && !wake_r[smr_pkg::WAKE_PIN_BIT]) == cfg4_r[smr_pkg::CFG4_POL_BIT];
    assign irq2_level = (wake_drive && wake_r[smr_pkg::WAKE_PIN_BIT]) == cfg4_r[smr_pkg::CFG4_POL_BIT];

    // First interrupt pin: level follows polarity, open drain only pulls low
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            first_irq_pin_o      <= 1'b0;
            first_irq_pin_oe_n_o <= 1'b1;
        end else begin
            first_irq_pin_o      <= irq1_level;
            // Open drain pulls low only; the high level is released
            first_irq_pin_oe_n_o <= cfg4_r[smr_pkg::CFG4_DRIVE_BIT] && irq1_level;
        end
    end

    // Second pin is released while it serves as trigger input
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            second_irq_pin_o      <= 1'b0;
            second_irq_pin_oe_n_o <= 1'b1;
        end else if (second_is_input) begin
            second_irq_pin_o      <= 1'b0;
            second_irq_pin_oe_n_o <= 1'b1;
        end else begin
            second_irq_pin_o      <= irq2_level;
            second_irq_pin_oe_n_o <= cfg4_r[smr_pkg::CFG4_DRIVE_BIT] && irq2_level;
        end
    end

    // Host boot wait needs no logic here:
    // the reload settles in a few cycles,
    // well inside any boot time.

endmodule : smr_top

`default_nettype wire
